// file: core/sadc_ctrl.sv
// Conversion control, sequencer and serial link of the SAR converter
`timescale 1ns/1ps
module sadc_ctrl
    import sadc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic convert_start,
    input wire logic device_reset,
    input wire logic read_enable_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe_n,
    output logic busy,
    output logic nap,
    input wire logic cmp_hi,
    output logic [RES_W-1:0] dac_code,
    output logic [CHAN_W-1:0] conv_channel,
    output logic [1:0] conv_range,
    output logic gain_compression
);
    localparam int CONV_HI = CONV_CYC + 4;

    // Agreed level: follows the last two stages only when they match
    function automatic logic [2:0] sadc_agree(input logic [2:0] s2, input logic [2:0] s3,
                                              input logic [2:0] old);
        logic [2:0] same;
        same = ~(s2 ^ s3);
        return (same & s3) | (~same & old);
    endfunction : sadc_agree

    // Output coding per input range
    function automatic logic [RES_W-1:0] sadc_code(input logic [RES_W-1:0] raw,
                                                   input logic [1:0] rng);
        logic twos;
        twos = (rng == RANGE_FD_TC) || (rng == RANGE_PB);
        return twos ? {~raw[RES_W-1], raw[RES_W-2:0]} : raw;
    endfunction : sadc_code

    sadc_state_e state_r;
    sadc_state_e state_nxt;
    logic [2:0] pin_in;
    logic [2:0] sy1_r;
    logic [2:0] sy2_r;
    logic [2:0] sy3_r;
    logic [2:0] lvl_r;
    logic [2:0] lvl_nxt;
    logic cnv_rise;
    logic rst_lvl;
    logic rx_evt;
    logic sw_start;
    logic start_req;
    logic sar_start;
    logic sar_done;
    logic [RES_W-1:0] sar_raw;
    logic [CFG_W-1:0] ctrl_cfg_r;
    logic [CFG_W-1:0] seq_mem [SEQ_DEPTH];
    logic [LEN_W-1:0] seq_len_r;
    logic [PTR_W-1:0] seq_ptr_r;
    logic [CFG_W-1:0] cur_cfg;
    logic [CHAN_W-1:0] conv_chan_r;
    logic [1:0] conv_range_r;
    logic conv_gc_r;
    logic [OUT_W-1:0] out_word_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;
    logic mapped;
    logic lnk_clr;
    logic [CNT_W-1:0] tx_cnt_r;
    logic [2:0] rx_cnt_r;
    logic [WORD_W-2:0] rx_sh_r;
    logic rx_seen_r;
    logic rx_last;
    logic [CFG_W:0] rx_hold_r;
    logic rx_tog_r;

    // Pin and cross-domain synchronisers
    assign pin_in = {rx_tog_r, device_reset, convert_start};
    assign lvl_nxt = sadc_agree(sy2_r, sy3_r, lvl_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_r <= 3'h0;
            sy2_r <= 3'h0;
            sy3_r <= 3'h0;
            lvl_r <= 3'h0;
        end else begin
            sy1_r <= pin_in;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign cnv_rise = lvl_nxt[0] & ~lvl_r[0];
    assign rst_lvl = lvl_r[1];
    assign rx_evt = lvl_nxt[2] ^ lvl_r[2];

    // APB slave, zero wait states
    assign pready = 1'b1;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_RESULT);
    assign pslverr = psel & penable & ~mapped;
    assign sw_start = psel & penable & pwrite & pstrb[0] & (paddr == REG_CTRL)
                      & pwdata[CTRL_START_BIT];

    always_comb begin
        rd_mux = 32'h0;
        if (paddr == REG_CTRL) begin
            rd_mux[CTRL_CFG_LSB +: CFG_W] = ctrl_cfg_r;
        end else if (paddr == REG_STATUS) begin
            rd_mux[ST_BUSY_BIT] = busy;
            rd_mux[ST_NAP_BIT] = nap;
            rd_mux[ST_HALT_BIT] = (state_r == ST_HALT);
            rd_mux[ST_LEN_LSB +: LEN_W] = seq_len_r;
            rd_mux[ST_PTR_LSB +: PTR_W] = seq_ptr_r;
        end else if (paddr == REG_RESULT) begin
            rd_mux[OUT_W-1:0] = out_word_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_cfg_r <= CFG_RESET;
        end else if (psel && penable && pwrite && pstrb[0] && paddr == REG_CTRL) begin
            ctrl_cfg_r <= pwdata[CTRL_CFG_LSB +: CFG_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (psel && !penable) begin
            prdata_r <= rd_mux;
        end
    end

    assign prdata = prdata_r;

    // Conversion state machine
    assign start_req = cnv_rise | sw_start;

    always_comb begin
        state_nxt = state_r;
        sar_start = 1'b0;
        unique case (state_r)
            ST_NAP: begin
                if (start_req) begin
                    state_nxt = ST_CONV;
                    sar_start = ~rst_lvl;
                end
            end
            ST_CONV: begin
                if (sar_done) begin
                    state_nxt = ST_NAP;
                end
            end
            ST_HALT: begin
                state_nxt = ST_NAP;
            end
            default: begin
                state_nxt = ST_NAP;
            end
        endcase
        if (rst_lvl) begin
            state_nxt = ST_HALT;
            sar_start = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_NAP;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign busy = (state_r == ST_CONV);
    assign nap = (state_r == ST_NAP);

    sadc_sar #(
        .RES(RES_W),
        .STEP(SAR_STEP_CYC)
    ) u_sar (
        .clk(pclk),
        .rst_n(presetn),
        .start(sar_start),
        .abort(rst_lvl),
        .cmp_hi(cmp_hi),
        .dac_code(dac_code),
        .active(),
        .done(sar_done),
        .result(sar_raw)
    );

    // Sequencer list: first valid word of a frame restarts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_len_r <= 5'h00;
            seq_ptr_r <= 4'h0;
        end else if (rst_lvl) begin
            seq_len_r <= 5'h00;
            seq_ptr_r <= 4'h0;
        end else if (rx_evt && rx_hold_r[CFG_W]) begin
            seq_len_r <= 5'h01;
            seq_ptr_r <= 4'h0;
        end else begin
            if (rx_evt && seq_len_r != LEN_W'(SEQ_DEPTH)) begin
                seq_len_r <= seq_len_r + 5'h01;
            end
            if (sar_start && seq_len_r != 5'h00) begin
                seq_ptr_r <= ({1'b0, seq_ptr_r} + 5'h01 == seq_len_r) ? 4'h0 : seq_ptr_r + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (rx_evt && !rst_lvl) begin
            if (rx_hold_r[CFG_W]) begin
                seq_mem[0] <= rx_hold_r[CFG_W-1:0];
            end else if (seq_len_r != LEN_W'(SEQ_DEPTH)) begin
                seq_mem[seq_len_r[PTR_W-1:0]] <= rx_hold_r[CFG_W-1:0];
            end
        end
    end

    assign cur_cfg = (seq_len_r == 5'h00) ? ctrl_cfg_r : seq_mem[seq_ptr_r];

    // Range and channel held in separate registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_chan_r <= '0;
            conv_range_r <= 2'h0;
            conv_gc_r <= 1'b0;
        end else if (sar_start) begin
            conv_chan_r <= cur_cfg[CFG_CHAN_LSB +: CHAN_W];
            conv_range_r <= cur_cfg[CFG_RANGE_LSB +: 2];
            conv_gc_r <= cur_cfg[CFG_GC_BIT];
        end
    end

    assign conv_channel = conv_chan_r;
    assign conv_range = conv_range_r;
    assign gain_compression = conv_gc_r;

    // Result plus applied configuration, ready when busy falls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_word_r <= '0;
        end else if (rst_lvl) begin
            out_word_r <= '0;
        end else if (sar_done) begin
            out_word_r <= {sadc_code(sar_raw, conv_range_r), 1'b1,
                           conv_chan_r, conv_range_r, conv_gc_r};
        end
    end

    // Shift-clock domain; held cleared while the bus is disabled
    assign lnk_clr = read_enable_n | ~presetn;
    assign rx_last = (rx_cnt_r == 3'h7) && rx_sh_r[WORD_W-2];

    always_ff @(posedge sck or posedge lnk_clr) begin
        if (lnk_clr) begin
            tx_cnt_r <= 5'h00;
            rx_cnt_r <= 3'h0;
            rx_sh_r <= '0;
            rx_seen_r <= 1'b0;
        end else begin
            if (tx_cnt_r != CNT_W'(OUT_W)) begin
                tx_cnt_r <= tx_cnt_r + 5'h01;
            end
            rx_cnt_r <= rx_cnt_r + 3'h1;
            rx_sh_r <= {rx_sh_r[WORD_W-3:0], sdi};
            if (rx_last) begin
                rx_seen_r <= 1'b1;
            end
        end
    end

    // Word handed to the fast side by toggle; stays stable between words
    always_ff @(posedge sck or negedge presetn) begin
        if (!presetn) begin
            rx_hold_r <= '0;
            rx_tog_r <= 1'b0;
        end else if (!read_enable_n && rx_last) begin
            rx_hold_r <= {~rx_seen_r, rx_sh_r[WORD_W-3:0], sdi};
            rx_tog_r <= ~rx_tog_r;
        end
    end

    // Result word is static while the host reads after busy falls
    assign sdo_o = (tx_cnt_r < CNT_W'(OUT_W)) ? out_word_r[CNT_W'(OUT_W - 1) - tx_cnt_r] : 1'b0;
    assign sdo_oe_n = read_enable_n | (state_r == ST_HALT);

    cnv_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnv_rise && state_r == ST_NAP && !rst_lvl |=> busy)
        else $error("convert edge did not start a conversion");

    busy_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(busy) |-> ##[1:CONV_HI] !busy)
        else $error("busy stayed high past conversion time");

    busy_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        sar_done && !rst_lvl |=> !busy && nap)
        else $error("busy did not fall after conversion");

    sdo_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        read_enable_n |-> sdo_oe_n)
        else $error("serial output driven while bus disabled");

    sdo_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        !read_enable_n && state_r != ST_HALT |-> !sdo_oe_n)
        else $error("serial output floating while bus enabled");

    halt_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        rst_lvl |=> !busy && sdo_oe_n)
        else $error("reset input did not halt the converter");

    uni_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        sar_done && !rst_lvl && conv_range_r == RANGE_PU |=>
        out_word_r[OUT_W-1 -: RES_W] == $past(sar_raw))
        else $error("unipolar result not straight binary");

    bip_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        sar_done && !rst_lvl && conv_range_r == RANGE_PB |=>
        out_word_r[OUT_W-1 -: RES_W] == {~$past(sar_raw[RES_W-1]), $past(sar_raw[RES_W-2:0])})
        else $error("bipolar result not two's complement");

    seq_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_evt && !rx_hold_r[CFG_W] && seq_len_r == LEN_W'(SEQ_DEPTH) |=>
        seq_len_r == LEN_W'(SEQ_DEPTH))
        else $error("sequencer grew beyond its depth");

    rx_gate_a: assert property (@(posedge sck) disable iff (!presetn)
        read_enable_n |=> rx_tog_r == $past(rx_tog_r))
        else $error("shift clock acted while bus disabled");
endmodule : sadc_ctrl

// file: core/sadc_pkg.sv
// Constants and types shared by the converter control block
package sadc_pkg;
    localparam int RES_W = 18;
    localparam int CFG_W = 7;
    localparam int WORD_W = CFG_W + 1;
    localparam int OUT_W = RES_W + WORD_W;
    localparam int SEQ_DEPTH = 16;
    localparam int LEN_W = 5;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    // Decision settling time counted in periods of the bus clock pclk
    localparam int CLK_PERIOD_NS = 4;
    localparam int SAR_STEP_NS = 40;
    localparam int SAR_STEP_CYC = (SAR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC = RES_W * SAR_STEP_CYC;
    // Serial configuration word layout
    localparam int CFG_VALID_BIT = 7;
    localparam int CFG_CHAN_LSB = 3;
    localparam int CHAN_W = 4;
    localparam int CFG_RANGE_LSB = 1;
    localparam int CFG_GC_BIT = 0;
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
    // Register map
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] REG_RESULT = 12'h008;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CFG_LSB = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_NAP_BIT = 1;
    localparam int ST_HALT_BIT = 2;
    localparam int ST_LEN_LSB = 4;
    localparam int ST_PTR_LSB = 12;
    typedef enum logic [1:0] {
        RANGE_FD_SB = 2'h0,
        RANGE_FD_TC = 2'h1,
        RANGE_PU = 2'h2,
        RANGE_PB = 2'h3
    } sadc_range_e;
    typedef enum logic [2:0] {
        ST_NAP = 3'h1,
        ST_CONV = 3'h2,
        ST_HALT = 3'h4
    } sadc_state_e;
endpackage : sadc_pkg

// file: core/sadc_sar.sv
// Successive approximation stepper driving the capacitor DAC code
`timescale 1ns/1ps
module sadc_sar
    import sadc_pkg::*;
#(
    parameter int RES = RES_W,
    parameter int STEP = SAR_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic abort,
    input wire logic cmp_hi,
    output logic [RES-1:0] dac_code,
    output logic active,
    output logic done,
    output logic [RES-1:0] result
);
    localparam int SAR_LAT = RES * STEP + 1;
    logic [RES-1:0] code_r;
    logic [RES-1:0] trial_r;
    logic [RES-1:0] kept;
    logic [7:0] tmr_r;
    logic act_r;
    logic done_r;
    logic [RES-1:0] result_r;

    // Drop the trial bit when the sampled input lies below it
    assign kept = cmp_hi ? code_r : (code_r & ~trial_r);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_r <= '0;
            trial_r <= '0;
            tmr_r <= 8'h00;
            act_r <= 1'b0;
            done_r <= 1'b0;
            result_r <= '0;
        end else begin
            done_r <= 1'b0;
            if (abort) begin
                act_r <= 1'b0;
                code_r <= '0;
                trial_r <= '0;
            end else if (start) begin
                trial_r <= {1'b1, {(RES-1){1'b0}}};
                code_r <= {1'b1, {(RES-1){1'b0}}};
                tmr_r <= 8'h00;
                act_r <= 1'b1;
            end else if (act_r) begin
                if (tmr_r == 8'(STEP - 1)) begin
                    tmr_r <= 8'h00;
                    trial_r <= trial_r >> 1;
                    code_r <= kept | (trial_r >> 1);
                    if (trial_r[0]) begin
                        act_r <= 1'b0;
                        done_r <= 1'b1;
                        result_r <= kept;
                    end
                end else begin
                    tmr_r <= tmr_r + 8'h01;
                end
            end
        end
    end

    assign dac_code = code_r;
    assign active = act_r;
    assign done = done_r;
    assign result = result_r;

    sar_steps_a: assert property (@(posedge clk) disable iff (!rst_n || abort)
        start |-> ##SAR_LAT done)
        else $error("conversion did not take 18 decisions");
endmodule : sadc_sar

// file: tb/sadc_host.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
module sadc_host (
    input wire logic frame_go,
    input wire logic [135:0] tx_bits,
    input wire logic [7:0] n_bits,
    input wire logic sdo_o,
    input wire logic sdo_oe_n,
    output logic read_enable_n,
    output logic sck,
    output logic sdi,
    output logic [25:0] rx_word,
    output logic frame_done
);
    // Shift clock runs inside a frame; a few gated edges follow it
    initial begin
        read_enable_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b1;
        rx_word = '0;
        frame_done = 1'b1;
        forever begin
            @(posedge frame_go);
            frame_done = 1'b0;
            #7 read_enable_n = 1'b0;
            for (int i = 0; i < n_bits; i++) begin
                #20 sdi = tx_bits[135-i];
                #20 rx_word = {rx_word[24:0], (sdo_oe_n === 1'b0) ? sdo_o : 1'bx};
                sck = 1'b1;
                #40 sck = 1'b0;
            end
            #20 read_enable_n = 1'b1;
            // Released data line shows no stale value
            sdi = ~sdi;
            // Stray edges while disabled must leave the list alone
            repeat (8) begin
                #40 sck = 1'b1;
                #40 sck = 1'b0;
            end
            frame_done = 1'b1;
        end
    end
endmodule : sadc_host

// file: tb/sar_adc_serial_control_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_serial_control_bench
    import sadc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic convert_start = 1'b0;
    logic device_reset = 1'b0;
    logic fr_go = 1'b0;
    logic [135:0] fr_tx = '0;
    logic [7:0] fr_n = 8'h1a;
    logic [RES_W-1:0] vin = '0;
    logic pready, pslverr, sdo_o, sdo_oe_n, busy, nap, read_enable_n, sck, sdi, frame_done, cmp_hi, err;
    logic [31:0] prdata, rd;
    logic [RES_W-1:0] dac_code;
    logic [CHAN_W-1:0] conv_channel;
    logic [1:0] conv_range;
    logic gain_compression;
    logic [25:0] rx_word;
    logic [7:0] cfg [4];
    int seed = 70736;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    longint t0;

    always #2 pclk = ~pclk;
    // Comparator of an ideal sampled input
    assign cmp_hi = (vin >= dac_code);

    sadc_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .convert_start(convert_start), .device_reset(device_reset),
        .read_enable_n(read_enable_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
        .busy(busy), .nap(nap), .cmp_hi(cmp_hi), .dac_code(dac_code), .conv_channel(conv_channel),
        .conv_range(conv_range), .gain_compression(gain_compression));
    sadc_host host (.frame_go(fr_go), .tx_bits(fr_tx), .n_bits(fr_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
        .read_enable_n(read_enable_n), .sck(sck), .sdi(sdi), .rx_word(rx_word), .frame_done(frame_done));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic frame(input logic [135:0] tx, input logic [7:0] n);
        @(posedge pclk);
        fr_tx <= tx;
        fr_n <= n;
        fr_go <= 1'b1;
        @(posedge pclk);
        fr_go <= 1'b0;
        while (frame_done !== 1'b1) @(posedge pclk);
    endtask : frame

    task automatic convert(input logic pin, input logic [31:0] cw);
        if (pin) begin
            @(posedge pclk);
            convert_start <= 1'b1;
        end else begin
            apb(1'b1, REG_CTRL, cw);
        end
        while (busy !== 1'b1) @(posedge pclk);
        t0 = $time;
        chk("nap_conv", nap, 32'h0);
        // Second start while busy must be ignored
        apb(1'b1, REG_CTRL, cw);
        convert_start <= 1'b0;
        while (busy === 1'b1) @(posedge pclk);
        chk("busy_len", 32'(($time - t0) / CLK_PERIOD_NS), 32'(RES_W * SAR_STEP_CYC + 1));
    endtask : convert

    function automatic logic [25:0] exp_word(input logic [17:0] v, input logic [7:0] c);
        logic [17:0] code;
        code = c[CFG_RANGE_LSB] ? {~v[17], v[16:0]} : v;
        return {code, 1'b1, c[6:0]};
    endfunction : exp_word

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("busy_rst", busy, 32'h0);
        chk("nap_rst", nap, 32'h1);
        chk("oe_idle", sdo_oe_n, 32'h1);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status_rst", rd, 32'h2);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped_err", err, 32'h1);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl_rst", rd, 32'h0);
        for (int r = 0; r < 4; r++) cfg[r] = {1'b1, 4'($random(seed)), 2'(r), 1'($random(seed))};
        frame({8'h7f, cfg[0], cfg[1], cfg[2], cfg[3], 96'h0}, 8'h28);
        repeat (8) @(posedge pclk);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("seq_len", (rd >> ST_LEN_LSB) & 32'h1f, 32'h4);
        for (int r = 0; r < 4; r++) begin
            vin <= (r == 0) ? 18'h00000 : (r == 1) ? 18'h3ffff : 18'($random(seed));
            convert(r[0], 32'h1);
            chk("conv_cfg", {conv_channel, conv_range, gain_compression}, cfg[r][6:0]);
            chk("nap_idle", nap, 32'h1);
            apb(1'b0, REG_RESULT, 32'h0);
            chk("result_reg", rd, exp_word(vin, cfg[r]));
            // Busy already low before the frame opens
            frame('0, 8'h1a);
            chk("serial_word", rx_word, exp_word(vin, cfg[r]));
        end
        frame({17{8'h80}}, 8'h88);
        repeat (8) @(posedge pclk);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("seq_full", (rd >> ST_LEN_LSB) & 32'h1f, 32'h10);
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (20) @(posedge pclk);
        device_reset <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("busy_halt", busy, 32'h0);
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        chk("start_halt", busy, 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status_halt", rd & 32'h1ff, 32'h4);
        frame('0, 8'h1a);
        chk("bus_float", {6'h0, rx_word}, {6'h0, {26{1'bx}}});
        device_reset <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("nap_back", nap, 32'h1);
        // Empty list: a conversion takes the default word of the control register
        cfg[0] = 8'($random(seed));
        vin <= 18'($random(seed));
        apb(1'b1, REG_CTRL, {24'h0, cfg[0][6:0], 1'b0});
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl_cfg", rd, {24'h0, cfg[0][6:0], 1'b0});
        convert(1'b0, {24'h0, cfg[0][6:0], 1'b1});
        chk("dflt_cfg", {conv_channel, conv_range, gain_compression}, cfg[0][6:0]);
        apb(1'b0, REG_RESULT, 32'h0);
        chk("dflt_result", rd, exp_word(vin, cfg[0]));
        results();
    end
endmodule : sar_adc_serial_control_bench
